// ---- design/lpsr_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpsr_top
  import lpsr_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = LPSR_FIFO_DEPTH
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [LPSR_WIDTH-1:0] par_data,
  input  wire logic                  par_valid,
  output logic                       par_ready,
  input  wire logic                  latch_clk_pin,
  input  wire logic                  shift_clk_pin,
  input  wire logic                  shift_mode_pin,
  input  wire logic                  serial_in,
  input  wire logic                  out_en_n_pin,
  output logic                       serial_out,
  output logic                       serial_out_oe_n
);

  // ----------------------------------------------------------------
  // Parallel word queue
  // ----------------------------------------------------------------
  // Queued words stand in for the parallel inputs; the head is
  // what a latch edge sees. Empty queue: stale head is captured.
  logic [LPSR_WIDTH-1:0] head_data;
  logic                  head_valid;
  logic                  head_pop;

  lpsr_fifo #(
    .WIDTH (LPSR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (par_data),
    .in_valid  (par_valid),
    .in_ready  (par_ready),
    .out_data  (head_data),
    .out_valid (head_valid),
    .out_ready (head_pop)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  lpsr_pins_t pin_raw;
  lpsr_pins_t pin_s;
  lpsr_pins_t pin_d_ff;

  always_comb begin
    pin_raw            = LPSR_PINS_RST;
    pin_raw.latch_clk  = latch_clk_pin;
    pin_raw.shift_clk  = shift_clk_pin;
    pin_raw.shift_mode = shift_mode_pin;
    pin_raw.serial_in  = serial_in;
    pin_raw.out_en_n   = out_en_n_pin;
  end

  lpsr_sync #(
    .WIDTH (LPSR_PINS_W),
    .RST   (LPSR_PINS_RST)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pin_s)
  );

  // Delayed copy taken after the sync, for edge detection
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_d_ff <= LPSR_PINS_RST;
    end else begin
      pin_d_ff <= pin_s;
    end
  end

  logic latch_rise;
  logic shift_rise;

  assign latch_rise = pin_s.latch_clk & ~pin_d_ff.latch_clk;
  assign shift_rise = pin_s.shift_clk & ~pin_d_ff.shift_clk;
  assign head_pop   = latch_rise & head_valid;

  // ----------------------------------------------------------------
  // Data latch
  // ----------------------------------------------------------------
  logic [LPSR_WIDTH-1:0] latch_ff;
  logic [LPSR_WIDTH-1:0] nxt_latch;

  assign nxt_latch = latch_rise ? head_data : latch_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch_ff <= LPSR_LATCH_RST;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Load mode is transparent: follows the latch's next value so a
  // capture and a load in one cycle agree. Output enable is not read.
  logic [LPSR_WIDTH-1:0] shreg_ff;
  logic [LPSR_WIDTH-1:0] nxt_shreg;

  always_comb begin
    nxt_shreg = shreg_ff;
    if (!pin_s.shift_mode) begin
      nxt_shreg = nxt_latch;
    end else if (shift_rise) begin
      nxt_shreg = {shreg_ff[LPSR_LAST_STAGE-1:0], pin_s.serial_in};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shreg_ff <= LPSR_SHREG_RST;
    end else begin
      shreg_ff <= nxt_shreg;
    end
  end

  // ----------------------------------------------------------------
  // Output driver
  // ----------------------------------------------------------------
  logic oe_n_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oe_n_ff <= LPSR_PINS_RST.out_en_n;
    end else begin
      oe_n_ff <= pin_s.out_en_n;
    end
  end

  assign serial_out      = shreg_ff[LPSR_LAST_STAGE];
  assign serial_out_oe_n = oe_n_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_latch_capture;
    @(posedge clock) disable iff (!rst_n)
    latch_rise |=> (latch_ff == $past(head_data));
  endproperty
  a_latch_capture: assert property (p_latch_capture)
    else $error("latch missed parallel word");

  property p_shift_in;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && shift_rise) |=> (shreg_ff[0] == $past(pin_s.serial_in));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not taken into first stage");

  property p_serial_ignored;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode && shift_rise) |=> (shreg_ff[0] == $past(nxt_latch[0]));
  endproperty
  a_serial_ignored: assert property (p_serial_ignored)
    else $error("serial input used in load mode");

  property p_parallel_load;
    @(posedge clock) disable iff (!rst_n)
    !pin_s.shift_mode |=> (shreg_ff == $past(nxt_latch));
  endproperty
  a_parallel_load: assert property (p_parallel_load)
    else $error("register not loaded from latch");

  property p_advance;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && shift_rise)
      |=> (shreg_ff[LPSR_LAST_STAGE:1] == $past(shreg_ff[LPSR_LAST_STAGE-1:0]));
  endproperty
  a_advance: assert property (p_advance)
    else $error("stages did not advance");

  property p_out_enable;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.out_en_n != $past(pin_s.out_en_n)) |=> (serial_out_oe_n == $past(pin_s.out_en_n));
  endproperty
  a_out_enable: assert property (p_out_enable)
    else $error("output enable did not follow pin");

  property p_enable_isolated;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && !shift_rise && (pin_s.out_en_n != pin_d_ff.out_en_n))
      |=> (shreg_ff == $past(shreg_ff));
  endproperty
  a_enable_isolated: assert property (p_enable_isolated)
    else $error("enable altered register contents");

  property p_last_stage_out;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && shift_rise) |=> (serial_out == $past(shreg_ff[LPSR_LAST_STAGE-1]));
  endproperty
  a_last_stage_out: assert property (p_last_stage_out)
    else $error("serial output not last stage");

  property p_follow_latch;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode) [*2] |-> (shreg_ff == latch_ff);
  endproperty
  a_follow_latch: assert property (p_follow_latch)
    else $error("register not following latch in load mode");

  // ----------------------------------------------------------------
  // Checks: what must stay put
  // ----------------------------------------------------------------
  property p_latch_hold;
    @(posedge clock) disable iff (!rst_n)
    !latch_rise |=> (latch_ff == $past(latch_ff));
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without a latch edge");

  // A held latch clock must capture once, not every cycle
  property p_one_capture;
    @(posedge clock) disable iff (!rst_n)
    latch_rise |=> !latch_rise;
  endproperty
  a_one_capture: assert property (p_one_capture)
    else $error("latch edge seen twice");

  property p_one_shift;
    @(posedge clock) disable iff (!rst_n)
    shift_rise |=> !shift_rise;
  endproperty
  a_one_shift: assert property (p_one_shift)
    else $error("shift edge seen twice");

  property p_shift_hold;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && !shift_rise) |=> (shreg_ff == $past(shreg_ff));
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("register moved without a shift edge");

  property p_serial_blocked;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode && (pin_s.serial_in != $past(pin_s.serial_in))) |=> (shreg_ff == $past(nxt_latch));
  endproperty
  a_serial_blocked: assert property (p_serial_blocked)
    else $error("serial input change reached register in load mode");

  property p_load_from_latch;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode && !latch_rise) |=> (shreg_ff == $past(latch_ff));
  endproperty
  a_load_from_latch: assert property (p_load_from_latch)
    else $error("register differs from held latch in load mode");

  property p_load_out;
    @(posedge clock) disable iff (!rst_n)
    !pin_s.shift_mode |=> (serial_out == $past(nxt_latch[LPSR_LAST_STAGE]));
  endproperty
  a_load_out: assert property (p_load_out)
    else $error("serial output not latch top bit in load mode");

  property p_out_hold;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.shift_mode && !shift_rise) |=> $stable(serial_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("serial output moved without a shift");

  // Enable is a pure one-cycle register of the synced pin
  property p_oe_track;
    @(posedge clock) disable iff (!rst_n)
    1'h1 |=> (serial_out_oe_n == $past(pin_s.out_en_n));
  endproperty
  a_oe_track: assert property (p_oe_track)
    else $error("output enable not one cycle behind pin");

  property p_oe_latch_isolated;
    @(posedge clock) disable iff (!rst_n)
    ((pin_s.out_en_n != pin_d_ff.out_en_n) && !latch_rise) |=> (latch_ff == $past(latch_ff));
  endproperty
  a_oe_latch_isolated: assert property (p_oe_latch_isolated)
    else $error("enable altered latch contents");

  property p_oe_load_isolated;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode && (pin_s.out_en_n != pin_d_ff.out_en_n)) |=> (shreg_ff == $past(nxt_latch));
  endproperty
  a_oe_load_isolated: assert property (p_oe_load_isolated)
    else $error("enable altered register in load mode");

  property p_no_shift_in_load;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.shift_mode && shift_rise) |=> (serial_out == $past(nxt_latch[LPSR_LAST_STAGE]));
  endproperty
  a_no_shift_in_load: assert property (p_no_shift_in_load)
    else $error("shift edge acted in load mode");

  property p_mode_return;
    @(posedge clock) disable iff (!rst_n)
    ($rose(pin_s.shift_mode) && !shift_rise) |=> (shreg_ff == $past(shreg_ff));
  endproperty
  a_mode_return: assert property (p_mode_return)
    else $error("register moved when select returned high");

endmodule : lpsr_top

`default_nettype wire

// ---- shared/lpsr_pkg.sv ----
// Operation
// - Latch clock rise captures all eight parallel bits
// - Select high: shift clock rise takes serial bit
// - Select low: serial input is ignored
// - Select low: register loads from data latch
// - Each shift moves every stage one place on
// - Output driven only while enable low
// - Enable never alters latch or register contents
// - Serial output shows the final register stage
`default_nettype none

package lpsr_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int unsigned LPSR_WIDTH      = 8;
  localparam int unsigned LPSR_LAST_STAGE = LPSR_WIDTH - 1;
  localparam int unsigned LPSR_FIFO_DEPTH = 16;
  localparam int unsigned LPSR_SYNC_DEPTH = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [LPSR_WIDTH-1:0] LPSR_LATCH_RST = 8'h00;
  localparam logic [LPSR_WIDTH-1:0] LPSR_SHREG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Host pin bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latch_clk;
    logic shift_clk;
    logic shift_mode;
    logic serial_in;
    logic out_en_n;
  } lpsr_pins_t;

  localparam int unsigned LPSR_PINS_W = $bits(lpsr_pins_t);

  // Output disabled and clocks low until the pins are seen
  localparam lpsr_pins_t LPSR_PINS_RST = '{
    latch_clk:  1'h0,
    shift_clk:  1'h0,
    shift_mode: 1'h1,
    serial_in:  1'h0,
    out_en_n:   1'h1
  };

endpackage : lpsr_pkg

`default_nettype wire

// ---- design/lpsr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpsr_sync #(
  parameter int unsigned        WIDTH = 1,
  parameter logic [WIDTH-1:0]   RST   = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // Two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= RST;
      sync_ff <= RST;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : lpsr_sync

`default_nettype wire

// ---- design/lpsr_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpsr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      nxt_count;
  logic             ready_ff;
  logic             valid_ff;
  logic [WIDTH-1:0] rd_data_ff;
  logic             push;
  logic             pop;

  assign push = in_valid & ready_ff;
  assign pop  = out_ready & valid_ff;

  always_comb begin
    nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'h1) : rd_ptr_ff;
    nxt_count  = count_ff;
    if (push && !pop) begin
      nxt_count = (AW+1)'(count_ff + 1'h1);
    end else if (pop && !push) begin
      nxt_count = (AW+1)'(count_ff - 1'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'h1) : wr_ptr_ff;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  // Flags registered so both ports come straight from flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_ff <= 1'h0;
      valid_ff <= 1'h0;
    end else begin
      ready_ff <= (nxt_count != (AW+1)'(DEPTH));
      valid_ff <= (nxt_count != '0);
    end
  end

  // Head word registered; bypass when writing the slot being read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (push && (wr_ptr_ff == nxt_rd_ptr)) begin
      rd_data_ff <= in_data;
    end else begin
      rd_data_ff <= mem[nxt_rd_ptr];
    end
  end

  assign in_ready  = ready_ff;
  assign out_valid = valid_ff;
  assign out_data  = rd_data_ff;

endmodule : lpsr_fifo

`default_nettype wire

// ---- tb/lpsr_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module lpsr_host (
  input  wire logic clock,
  input  wire logic line,
  output logic      latch_clk,
  output logic      shift_clk,
  output logic      shift_mode,
  output logic      serial_in,
  output logic      out_en_n
);
  localparam logic LO = 1'h0;
  localparam logic HI = 1'h1;

  initial begin
    latch_clk  = LO;
    shift_clk  = LO;
    shift_mode = HI;
    serial_in  = LO;
    out_en_n   = HI;
  end

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Four cycles a level: the pins pass a two-edge sync path
  task automatic drive(input logic lc, input logic sc, input logic sm, input logic si, input logic oe);
    latch_clk  = lc;
    shift_clk  = sc;
    shift_mode = sm;
    serial_in  = si;
    out_en_n   = oe;
    repeat (4) @(posedge clock);
    #1;
  endtask : drive

  // ----------------------------------------------------------------
  // Latch, load, then shift n bits out MSB first
  // ----------------------------------------------------------------
  task automatic transfer(input logic [7:0] sin, input int n, output logic [15:0] got);
    logic b;
    got = 16'h0000;
    drive(HI, LO, HI, LO, HI);
    drive(LO, LO, HI, LO, HI);
    drive(LO, LO, LO, LO, HI);
    drive(LO, LO, HI, LO, LO);
    for (int k = 0; k < n; k++) begin
      got = {got[14:0], line};
      // Data set a full level ahead of the clock rise for setup
      b = (k < 8) ? sin[7-k] : LO;
      drive(LO, LO, HI, b, LO);
      drive(LO, HI, HI, b, LO);
    end
    drive(LO, LO, HI, LO, HI);
  endtask : transfer
endmodule : lpsr_host

`default_nettype wire

// ---- tb/latched_piso_shift_register_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module latched_piso_shift_register_test import lpsr_pkg::*;;
  logic                  clock;
  logic                  rst_n;
  logic                  par_valid;
  logic                  last_out;
  logic [LPSR_WIDTH-1:0] par_data;
  logic [15:0]           got;
  wire logic             par_ready;
  wire logic             serial_out;
  wire logic             serial_out_oe_n;
  wire logic             line;
  wire logic             lc;
  wire logic             sc;
  wire logic             sm;
  wire logic             si;
  wire logic             oe;
  int                    num_errors;
  int                    samples_checked;
  // Columns: word, serial_in byte, expected 16 bits out
  logic [31:0]           rows [4] = '{32'ha53ca53c, 32'hff00ff00, 32'h00ff00ff, 32'h817e817e};

  // No pull on the line: a released line shows the inverse level
  assign line = serial_out_oe_n ? ~last_out : serial_out;
  always @(posedge clock) begin
    if (serial_out_oe_n === 1'h0) begin
      last_out <= serial_out;
    end
  end

  lpsr_top i_lpsr_top (.clock(clock), .rst_n(rst_n), .par_data(par_data), .par_valid(par_valid),
    .par_ready(par_ready), .latch_clk_pin(lc), .shift_clk_pin(sc), .shift_mode_pin(sm), .serial_in(si),
    .out_en_n_pin(oe), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  lpsr_host i_lpsr_host (.clock(clock), .line(line), .latch_clk(lc), .shift_clk(sc), .shift_mode(sm),
    .serial_in(si), .out_en_n(oe));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  // Leaves par_valid up so back-to-back pushes need no gap
  task automatic push(input logic [7:0] w);
    int i;
    par_data  = w;
    par_valid = 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge clock);
      if (par_ready === 1'h1) break;
    end
    #1;
    if (i == 100) begin
      num_errors++;
      end_sim();
    end
  endtask : push

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    par_valid = 1'h0;
    par_data = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    repeat (15) @(posedge clock);
    #1;
    check(16'(par_ready), 16'h0000);
    check(16'(serial_out_oe_n), 16'h0001);
    check(16'(serial_out), 16'h0000);
    @(posedge clock);
    #1;
    rst_n = 1'h1;
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      push(rows[r][31:24]);
      par_valid = 1'h0;
      i_lpsr_host.transfer(rows[r][23:16], 16, got);
      check(got, rows[r][15:0]);
    end
    $display("test rows done");
    push(8'h80);
    par_valid = 1'h0;
    i_lpsr_host.transfer(8'h00, 8, got);
    check(got, 16'h0080);
    push(8'h5a);
    par_valid = 1'h0;
    i_lpsr_host.drive(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    check(16'(serial_out), 16'h0001);
    i_lpsr_host.drive(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    i_lpsr_host.drive(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    check(16'(serial_out), 16'h0001);
    i_lpsr_host.drive(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    check(16'(serial_out), 16'h0000);
    i_lpsr_host.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    i_lpsr_host.drive(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    check(16'(serial_out), 16'h0001);
    i_lpsr_host.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    check(16'(serial_out_oe_n), 16'h0001);
    // Shift while the driver is off: contents must still move
    i_lpsr_host.drive(1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    i_lpsr_host.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    check(16'(serial_out_oe_n), 16'h0000);
    check(16'(serial_out), 16'h0000);
    $display("test mode and enable done");
    for (int i = 0; i < 16; i++) begin
      push(8'h10 + 8'(i));
    end
    par_valid = 1'h0;
    repeat (2) @(posedge clock);
    #1;
    check(16'(par_ready), 16'h0000);
    par_data = 8'hee;
    par_valid = 1'h1;
    repeat (4) @(posedge clock);
    #1;
    par_valid = 1'h0;
    for (int i = 0; i < 16; i++) begin
      i_lpsr_host.transfer(8'h00, 8, got);
      check(got, 16'h0010 + 16'(i));
    end
    check(16'(par_ready), 16'h0001);
    $display("test buffer done");
    // Reset mid-run with a word queued and the driver on
    push(8'hc3);
    push(8'ha5);
    par_valid = 1'h0;
    i_lpsr_host.drive(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    i_lpsr_host.drive(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    check(16'(serial_out), 16'h0001);
    rst_n = 1'h0;
    repeat (3) @(posedge clock);
    #1;
    check(16'(par_ready), 16'h0000);
    check(16'(serial_out_oe_n), 16'h0001);
    check(16'(serial_out), 16'h0000);
    rst_n = 1'h1;
    i_lpsr_host.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    check(16'(par_ready), 16'h0001);
    // Queued word must be flushed: next capture is the fresh one
    push(8'h3c);
    par_valid = 1'h0;
    i_lpsr_host.transfer(8'h00, 8, got);
    check(got, 16'h003c);
    $display("test reset mid-run done");
    end_sim();
  end
endmodule : latched_piso_shift_register_test

`default_nettype wire
